//--- verilog/toc_pkg.sv
// Package with constants, register map and types for the trip output controller.
package toc_pkg;
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned HOLD_MS = 100;
   localparam int unsigned HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_MS;
   localparam int unsigned PULSE_MS = 100;
   localparam int unsigned PULSE_CYCLES = (CLK_HZ / 1000) * PULSE_MS;
   localparam int unsigned HOLD_W = 24;
   localparam int unsigned AUX_N = 8;
   localparam int unsigned ADDR_W = 8;
   localparam logic [4:0] NODE_ADDR_MIN = 5'h01;
   localparam logic [4:0] NODE_ADDR_MAX = 5'h1f;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h10;
   localparam logic [ADDR_W-1:0] REG_LINK = 8'h14;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam logic [31:0] LINK_RESET = 32'h00000001;
   localparam int unsigned CTRL_SEC_LSB = 0;
   localparam int unsigned CTRL_AUXM_LSB = 2;
   localparam int unsigned LINK_ADDR_LSB = 0;
   localparam int unsigned LINK_BAUD_LSB = 8;
   localparam int unsigned IRQ_N = 4;
   localparam int unsigned IRQ_TRIP = 0;
   localparam int unsigned IRQ_RELEASE = 1;
   localparam int unsigned IRQ_FAULT = 2;
   localparam int unsigned IRQ_ADDR_BAD = 3;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {SEC_FOLLOW, SEC_LOCKOUT, SEC_GROUND, SEC_SPARE} toc_sec_mode_type;
   typedef enum logic [1:0] {AUX_PULSED, AUX_CAUSE, AUX_PICKUP, AUX_BOTH} toc_aux_mode_type;
   typedef enum logic [1:0] {ST_IDLE, ST_TRIPPED, ST_HOLD} toc_state_type;
endpackage

//--- verilog/toc_link_turn.sv
// Half-duplex turn control for the shared serial pair.
`timescale 1ns/1ps
module toc_link_turn
   import toc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tx_req,
   input wire logic tx_bit,
   input wire logic four_wire,
   output logic line_o,
   output logic line_oe,
   output logic tx_active
);
   // The pair is driven while a transmit turn is open or four_wire is set; released otherwise.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_o <= 1'b1;
         line_oe <= 1'b0;
         tx_active <= 1'b0;
      end else begin
         tx_active <= tx_req;
         line_oe <= tx_req | four_wire;
         line_o <= tx_req ? tx_bit : 1'b1;
      end
   end

   property p_release_off_turn;
      @(posedge aclk) disable iff (!aresetn) (!tx_req && !four_wire) |=> !line_oe;
   endproperty
   a_release_off_turn: assert property (p_release_off_turn)
      else $error("line driven outside transmit turn");
   property p_drive_on_turn;
      @(posedge aclk) disable iff (!aresetn) tx_req |=> (line_oe && line_o == $past(tx_bit));
   endproperty
   a_drive_on_turn: assert property (p_drive_on_turn)
      else $error("line not driven during transmit turn");
endmodule // toc_link_turn

//--- verilog/toc_trip_output.sv
// Trip, health and auxiliary output sequencing with an AXI4-Lite register slave.
// Functional notes
// - Trip asserts both main and secondary trip outputs; open otherwise.
// - Hold trips until all currents zero, then 100 ms more, then release.
// - Secondary trip follows main, acts as lockout, or as ground fault.
// - Health output energized normally, dropped on internal fault.
// - Eight status outputs; two mode bits pick pulsed, cause, pickup or both.
// - Drive the shared pair only during own transmit turn; the code also drives it whenever four_wire is set.
// - Each node needs a unique address; all nodes share one baud rate.
// - Node address range allows at most 31 units per channel.
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module toc_trip_output
   import toc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trip_req,
   input wire logic ground_trip,
   input wire logic [2:0] phase_zero,
   input wire logic ground_zero,
   input wire logic internal_fault,
   input wire logic [2:0] phase_pickup,
   input wire logic ground_pickup,
   input wire logic lockout_reset,
   input wire logic tx_req,
   input wire logic tx_bit,
   input wire logic four_wire,
   output logic trip_main,
   output logic trip_sec,
   output logic health,
   output logic [AUX_N-1:0] aux_out,
   output logic link_o,
   output logic link_oe,
   output logic irq
);
   // Registers.
   logic [31:0] ctrl;
   logic [31:0] link_cfg;
   logic [IRQ_N-1:0] irq_stat;
   logic [IRQ_N-1:0] irq_en;
   toc_state_type state;
   logic [HOLD_W-1:0] hold_cnt;
   logic [HOLD_W-1:0] pulse_cnt;
   logic lockout;
   logic [AUX_N-1:0] cause;
   logic trip_q;
   logic tx_active;
   default clocking cb_main @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Configuration fields.
   toc_sec_mode_type sec_mode;
   toc_aux_mode_type aux_mode;
   wire logic [4:0] node_addr = link_cfg[LINK_ADDR_LSB +: 5];
   assign sec_mode = toc_sec_mode_type'(ctrl[CTRL_SEC_LSB +: 2]);
   assign aux_mode = toc_aux_mode_type'(ctrl[CTRL_AUXM_LSB +: 2]);
   // Address zero is broadcast; the five-bit field caps the channel at 31 units.
   wire logic addr_ok = (node_addr >= NODE_ADDR_MIN) && (node_addr <= NODE_ADDR_MAX);

   // Trip sequencer.
   wire logic all_zero = &{phase_zero, ground_zero};
   wire logic hold_done = (hold_cnt == HOLD_W'(HOLD_CYCLES - 1));
   wire logic trip_rise = trip_req & ~trip_q;
   wire logic tripping = (state != ST_IDLE);
   wire logic release_ev = (state == ST_HOLD) && hold_done && !trip_req;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         hold_cnt <= '0;
         trip_q <= 1'b0;
      end else begin
         trip_q <= trip_req;
         unique case (state)
            ST_IDLE: begin
               if (trip_req) begin
                  state <= ST_TRIPPED;
               end
            end
            ST_TRIPPED: begin
               hold_cnt <= '0;
               if (all_zero && !trip_req) begin
                  state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               hold_cnt <= hold_cnt + 1'b1;
               if (trip_req || !all_zero) begin
                  state <= ST_TRIPPED;
               end else if (hold_done) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Lockout latches until the operator resets it, and never while tripping.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lockout <= 1'b0;
      end else if (trip_req) begin
         lockout <= 1'b1;
      end else if (lockout_reset && !tripping) begin
         lockout <= 1'b0;
      end
   end

   logic next_sec;
   always_comb begin
      unique case (sec_mode)
         SEC_FOLLOW: next_sec = tripping;
         SEC_LOCKOUT: next_sec = lockout;
         SEC_GROUND: next_sec = tripping & ground_trip;
         SEC_SPARE: next_sec = tripping;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trip_main <= 1'b0;
         trip_sec <= 1'b0;
         health <= 1'b0;
      end else begin
         trip_main <= tripping | trip_req;
         trip_sec <= next_sec | (trip_req & (sec_mode != SEC_GROUND || ground_trip));
         health <= ~internal_fault;
      end
   end

   // Auxiliary outputs: bit 0-2 phase A-C, 3 ground, 4 trip, 5 ground trip, 6-7 spare.
   wire logic [AUX_N-1:0] pickup_v = {4'h0, ground_pickup, phase_pickup};
   wire logic [AUX_N-1:0] cause_v = {2'h0, ground_trip, 1'b1, ground_pickup, phase_pickup};
   logic [AUX_N-1:0] next_aux;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause <= '0;
         pulse_cnt <= '0;
      end else begin
         if (trip_rise) begin
            cause <= cause_v;
            pulse_cnt <= HOLD_W'(PULSE_CYCLES);
         end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 1'b1;
         end
         if (lockout_reset && !tripping && !trip_req) begin
            cause <= '0;
         end
      end
   end

   always_comb begin
      unique case (aux_mode)
         AUX_PULSED: next_aux = (pulse_cnt != '0) ? {AUX_N{1'b1}} : '0;
         AUX_CAUSE: next_aux = cause;
         AUX_PICKUP: next_aux = pickup_v;
         AUX_BOTH: next_aux = pickup_v | cause;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_out <= '0;
      end else begin
         aux_out <= next_aux;
      end
   end

   // Half-duplex pair; transmit is refused while the address is unusable.
   toc_link_turn u_link (
      .aclk(aclk),
      .aresetn(aresetn),
      .tx_req(tx_req & addr_ok),
      .tx_bit(tx_bit),
      .four_wire(four_wire),
      .line_o(link_o),
      .line_oe(link_oe),
      .tx_active(tx_active)
   );

   // AXI4-Lite slave: one write and one read outstanding, answer one cycle after both halves.
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire logic wr_go = aw_held && w_held && !s_axi_bvalid;
   wire logic wr_ctrl = wr_go && (aw_addr == REG_CTRL);
   wire logic wr_link = wr_go && (aw_addr == REG_LINK);
   wire logic wr_en = wr_go && (aw_addr == REG_IRQ_EN);
   wire logic wr_clr = wr_go && (aw_addr == REG_IRQ_CLR);
   wire logic wr_ok = wr_ctrl | wr_link | wr_en | wr_clr;
   wire logic [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire logic [IRQ_N-1:0] wmask_irq = wmask[IRQ_N-1:0];
   wire logic [IRQ_N-1:0] events = {!addr_ok, internal_fault & health, release_ev, trip_rise};
   wire logic [31:0] status_v = {24'h0, tx_active, addr_ok, lockout, health, trip_sec,
      trip_main, 2'(state)};
   wire logic rd_hit = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS) ||
      (s_axi_araddr == REG_IRQ_STAT) || (s_axi_araddr == REG_IRQ_CLR) ||
      (s_axi_araddr == REG_IRQ_EN) || (s_axi_araddr == REG_LINK);
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      if (s_axi_araddr == REG_CTRL) rd_mux = ctrl;
      if (s_axi_araddr == REG_STATUS) rd_mux = status_v;
      if (s_axi_araddr == REG_IRQ_STAT) rd_mux = {28'h0, irq_stat};
      if (s_axi_araddr == REG_IRQ_EN) rd_mux = {28'h0, irq_en};
      if (s_axi_araddr == REG_LINK) rd_mux = link_cfg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RESET;
         link_cfg <= LINK_RESET;
         irq_en <= '0;
         irq_stat <= '0;
      end else begin
         if (wr_ctrl) ctrl <= (ctrl & ~wmask) | (w_data & wmask);
         if (wr_link) link_cfg <= (link_cfg & ~wmask) | (w_data & wmask);
         if (wr_en) irq_en <= (irq_en & ~wmask_irq) | (w_data[IRQ_N-1:0] & wmask_irq);
         // Set wins over a clear in the same cycle so no event is lost.
         irq_stat <= (irq_stat & ~(wr_clr ? w_data[IRQ_N-1:0] & wmask[IRQ_N-1:0] : '0)) | events;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign irq = |(irq_stat & irq_en);

   // Assertions.
   property p_trip_both;
      (trip_req && sec_mode == SEC_FOLLOW) |=> (trip_main && trip_sec);
   endproperty
   a_trip_both: assert property (p_trip_both)
      else $error("trip outputs not both energized");
   property p_idle_open;
      (state == ST_IDLE && !trip_req) |=> !trip_main;
   endproperty
   a_idle_open: assert property (p_idle_open)
      else $error("main trip closed without a trip");
   property p_hold_until_zero;
      (state == ST_TRIPPED && !all_zero) |=> (state == ST_TRIPPED && trip_main);
   endproperty
   a_hold_until_zero: assert property (p_hold_until_zero)
      else $error("trip released before currents reached zero");
   property p_hold_time;
      (state == ST_HOLD && $past(state) == ST_HOLD) |-> hold_cnt != '0;
   endproperty
   a_hold_time: assert property (p_hold_time)
      else $error("hold counter not advancing");
   property p_lockout;
      (sec_mode == SEC_LOCKOUT && lockout && $past(lockout)) |=> trip_sec;
   endproperty
   a_lockout: assert property (p_lockout)
      else $error("lockout output not held");
   property p_ground_only;
      (sec_mode == SEC_GROUND && !ground_trip) |=> !trip_sec;
   endproperty
   a_ground_only: assert property (p_ground_only)
      else $error("ground output closed without ground trip");
   property p_health;
      internal_fault |=> !health;
   endproperty
   a_health: assert property (p_health)
      else $error("health output not dropped on fault");
   property p_aux_pickup;
      (aux_mode == AUX_PICKUP) |=> (aux_out == $past(pickup_v));
   endproperty
   a_aux_pickup: assert property (p_aux_pickup)
      else $error("aux outputs not following pickup");
   property p_addr_range;
      (node_addr == 5'h00) |-> !addr_ok;
   endproperty
   a_addr_range: assert property (p_addr_range)
      else $error("address zero accepted as node address");
endmodule // toc_trip_output

//--- test/toc_far_side.sv
// Far-side model: breaker with its trip coil and the remote serial master on the shared pair.
`timescale 1ns/1ps
module toc_far_side
   import toc_pkg::*;
#(
   parameter int OPEN_DELAY = 40
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic trip_main,
   input wire logic link_o,
   input wire logic link_oe,
   input wire logic master_oe,
   input wire logic master_bit,
   output logic [2:0] phase_zero,
   output logic ground_zero,
   output logic line
);
   logic [7:0] open_count;
   logic breaker_open;
   // The contacts need time to part, so currents only fall after the coil has pulled for a while.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         open_count <= 8'h00;
         breaker_open <= 1'b0;
      end else if (trip_main && !breaker_open) begin
         open_count <= open_count + 8'h01;
         breaker_open <= (open_count == 8'(OPEN_DELAY));
      end
   end
   assign phase_zero = {3{breaker_open}};
   assign ground_zero = breaker_open;
   // Idle bias pulls the pair high, so a released line never keeps showing the last bit.
   assign line = link_oe ? link_o : (master_oe ? master_bit : 1'b1);
endmodule // toc_far_side

//--- test/trip_output_control_tb.sv
// Self-checking testbench for the trip output controller.
`timescale 1ns/1ps
module trip_output_control_tb;
   import toc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0;
   logic [ADDR_W-1:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic trip_req = 1'b0, internal_fault = 1'b0, tx_req = 1'b0, tx_bit = 1'b0;
   logic four_wire = 1'b0, master_oe = 1'b0, master_bit = 1'b1;
   logic ground_trip = 1'b0, lockout_reset = 1'b0, ground_pickup = 1'b0;
   logic [2:0] phase_pickup = 3'h0;
   logic [2:0] phase_zero;
   logic ground_zero, trip_main, trip_sec, health, link_o, link_oe, irq, line;
   logic [AUX_N-1:0] aux_out;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;

   always #4 aclk = ~aclk;

   toc_trip_output i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trip_req(trip_req),
      .ground_trip(ground_trip), .phase_zero(phase_zero), .ground_zero(ground_zero),
      .internal_fault(internal_fault), .phase_pickup(phase_pickup),
      .ground_pickup(ground_pickup), .lockout_reset(lockout_reset), .tx_req(tx_req),
      .tx_bit(tx_bit), .four_wire(four_wire),
      .trip_main(trip_main), .trip_sec(trip_sec), .health(health), .aux_out(aux_out),
      .link_o(link_o), .link_oe(link_oe), .irq(irq));

   toc_far_side i_far (.aclk(aclk), .aresetn(aresetn), .trip_main(trip_main), .link_o(link_o),
      .link_oe(link_oe), .master_oe(master_oe), .master_bit(master_bit),
      .phase_zero(phase_zero), .ground_zero(ground_zero), .line(line));

   task automatic final_report;
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_bvalid) begin
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         @(posedge aclk);
      end
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] msk, input logic [31:0] exp,
                     input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_rvalid) begin
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         @(posedge aclk);
      end
      chk(s_axi_rdata & msk, exp);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // A hung handshake must still end in the closing report.
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report;
      end
   end

   initial begin
      tick(3);
      aresetn <= 1'b1;
      tick(3);
      chk_pin(health, 1'b1);
      chk_pin(trip_main, 1'b0);
      chk_pin(trip_sec, 1'b0);
      chk_pin(link_oe, 1'b0);
      rd(REG_CTRL, 32'hffffffff, CTRL_RESET, RESP_OKAY);
      rd(REG_LINK, 32'hffffffff, LINK_RESET, RESP_OKAY);
      rd(8'h18, 32'hffffffff, 32'h0, RESP_SLVERR);
      wr(8'h18, 32'h1, RESP_SLVERR);
      for (int m = 0; m < 16; m++) begin
         wr(REG_CTRL, 32'(m), RESP_OKAY);
         rd(REG_CTRL, 32'h0000000f, 32'(m), RESP_OKAY);
      end
      wr(REG_CTRL, 32'h0, RESP_OKAY);
      wr(REG_LINK, 32'h0000031f, RESP_OKAY);
      rd(REG_LINK, 32'h0000ff1f, 32'h0000031f, RESP_OKAY);
      rd(REG_STATUS, 32'h40, 32'h40, RESP_OKAY);
      tx_req <= 1'b1;
      tick(4);
      chk_pin(link_oe, 1'b1);
      chk_pin(line, 1'b0);
      tx_bit <= 1'b1;
      tick(4);
      chk_pin(line, 1'b1);
      tx_req <= 1'b0;
      master_oe <= 1'b1;
      master_bit <= 1'b0;
      tick(4);
      chk_pin(link_oe, 1'b0);
      chk_pin(line, 1'b0);
      master_oe <= 1'b0;
      wr(REG_LINK, 32'h00000300, RESP_OKAY);
      rd(REG_STATUS, 32'h40, 32'h0, RESP_OKAY);
      rd(REG_IRQ_STAT, 32'h8, 32'h8, RESP_OKAY);
      tx_req <= 1'b1;
      tick(4);
      chk_pin(link_oe, 1'b0);
      four_wire <= 1'b1;
      tick(4);
      chk_pin(link_oe, 1'b1);
      four_wire <= 1'b0;
      tx_req <= 1'b0;
      wr(REG_LINK, 32'h00000301, RESP_OKAY);
      wr(REG_IRQ_CLR, 32'hf, RESP_OKAY);
      wr(REG_IRQ_EN, 32'h1, RESP_OKAY);
      internal_fault <= 1'b1;
      tick(4);
      chk_pin(health, 1'b0);
      chk_pin(irq, 1'b0);
      rd(REG_IRQ_STAT, 32'h4, 32'h4, RESP_OKAY);
      wr(REG_IRQ_EN, 32'h5, RESP_OKAY);
      tick(2);
      chk_pin(irq, 1'b1);
      internal_fault <= 1'b0;
      wr(REG_IRQ_CLR, 32'h4, RESP_OKAY);
      tick(3);
      chk_pin(irq, 1'b0);
      chk_pin(health, 1'b1);
      trip_req <= 1'b1;
      tick(4);
      chk_pin(trip_main, 1'b1);
      chk_pin(trip_sec, 1'b1);
      chk({24'h0, aux_out}, 32'h000000ff);
      chk_pin(irq, 1'b1);
      rd(REG_STATUS, 32'h0c, 32'h0c, RESP_OKAY);
      trip_req <= 1'b0;
      tick(300);
      chk_pin(ground_zero, 1'b1);
      chk_pin(trip_main, 1'b1);
      chk_pin(trip_sec, 1'b1);
      wr(REG_CTRL, 32'h2, RESP_OKAY);
      tick(2);
      chk_pin(trip_sec, 1'b0);
      ground_trip <= 1'b1;
      tick(3);
      chk_pin(trip_sec, 1'b1);
      // Lockout must survive its reset while the breaker is still tripping.
      lockout_reset <= 1'b1;
      wr(REG_CTRL, 32'h5, RESP_OKAY);
      tick(2);
      chk_pin(trip_sec, 1'b1);
      chk({24'h0, aux_out}, 32'h00000010);
      lockout_reset <= 1'b0;
      phase_pickup <= 3'h5;
      ground_pickup <= 1'b1;
      wr(REG_CTRL, 32'h8, RESP_OKAY);
      tick(2);
      chk({24'h0, aux_out}, 32'h0000000d);
      wr(REG_CTRL, 32'hc, RESP_OKAY);
      tick(2);
      chk({24'h0, aux_out}, 32'h0000001d);
      wr(REG_IRQ_CLR, 32'h1, RESP_OKAY);
      tick(2);
      chk_pin(irq, 1'b0);
      rd(REG_IRQ_STAT, 32'h1, 32'h0, RESP_OKAY);
      final_report;
   end
endmodule // trip_output_control_tb
